/* File: bfpm_consts.vh */
// Constants for the motor fault protection monitor
`ifndef BFPM_CONSTS_VH
`define BFPM_CONSTS_VH
`define BFPM_CLK_MHZ 100
`define BFPM_CARRIER_US 100
`define BFPM_CARRIER_CYC (`BFPM_CARRIER_US * `BFPM_CLK_MHZ)
`define BFPM_TICK_MS 1
`define BFPM_TICK_CYC (`BFPM_TICK_MS * 1000 * `BFPM_CLK_MHZ)
`define BFPM_TIMEOUT_MS 20
`define BFPM_SPEED_MAX_RPM 33000
`define BFPM_ADC_FULL_V 26
`define BFPM_ADC_REF_V 5
`define BFPM_OV_LIMIT_RST 10'h3B0
`define BFPM_ADDR_CTRL 4'h0
`define BFPM_ADDR_STATUS 4'h1
`define BFPM_ADDR_SPEED 4'h2
`define BFPM_ADDR_OVLIM 4'h3
`define BFPM_ADDR_PWM 4'h4
`define BFPM_ADDR_VBUS 4'h5
`define BFPM_ADDR_TICKS 4'h6
`define BFPM_ERR_OV 0
`define BFPM_ERR_UV 1
`define BFPM_ERR_SHORT 2
`define BFPM_ERR_OC 3
`define BFPM_ERR_SPEED 4
`define BFPM_ERR_TMO 5
`define BFPM_ERR_PAT 6
`define BFPM_ERR_VBUS 7
`define BFPM_NERR 8
`endif

/* File: bfpm_tick_gen.v */
// Periodic pulse generator for carrier and millisecond tasks
`include "bfpm_consts.vh"
module bfpm_tick_gen #(
	parameter PERIOD = 100
) (
	input wire i_clk_sys,
	input wire i_sys_rst,
	output reg o_tick
);
	reg [31:0] cnt_ff;
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_ff <= 32'h0;
			o_tick <= 1'b0;
		end else if (cnt_ff == PERIOD - 1) begin
			cnt_ff <= 32'h0;
			o_tick <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
			o_tick <= 1'b0;
		end
	end
endmodule

/* File: bfpm_monitor.v */
// Fault protection monitor and PWM output gate for a sensorless BLDC drive
`include "bfpm_consts.vh"
module bfpm_monitor (
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_predriver_fault_a,
	input wire i_predriver_fault_b,
	input wire i_overcurrent,
	input wire [2:0] i_comp_uvw,
	input wire i_commutation,
	input wire [15:0] i_rotation_speed,
	input wire [9:0] i_bus_voltage_adc,
	input wire [5:0] i_pwm_timer,
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [15:0] o_rdata,
	output reg o_u_upper_pwm,
	output reg o_u_lower_pwm,
	output reg o_v_upper_pwm,
	output reg o_v_lower_pwm,
	output reg o_w_upper_pwm,
	output reg o_w_lower_pwm,
	output reg [5:0] o_pwm_oe,
	output reg o_overcurrent_irq,
	output reg o_carrier_sync_irq,
	output reg o_millisecond_tick_irq,
	output reg o_fault_stop,
	output reg [9:0] o_modulation_vbus
);
	wire carrier_tick;
	wire ms_tick;
	reg [`BFPM_NERR-1:0] err_ff;
	reg [`BFPM_NERR-1:0] nxt_err;
	reg run_en_ff;
	reg [9:0] ov_limit_ff;
	reg [15:0] speed_ff;
	reg [4:0] tmo_ms_ff;
	reg commut_seen_ff;
	reg [15:0] stop_cnt_ff;
	reg [15:0] start_ms_ff;
	reg [9:0] vbus_ff;
	reg [2:0] pat_ff;
	reg pat_bad_ff;
	reg clr_req;
	reg [15:0] rd_mux;
	wire stop_any;

	bfpm_tick_gen #(.PERIOD(`BFPM_CARRIER_CYC)) u_carrier (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.o_tick(carrier_tick)
	);
	bfpm_tick_gen #(.PERIOD(`BFPM_TICK_CYC)) u_millis (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.o_tick(ms_tick)
	);

	assign stop_any = |err_ff;

	// Error capture; a new event wins over a software clear
	always @* begin
		nxt_err = clr_req ? {`BFPM_NERR{1'b0}} : err_ff;
		case ({i_predriver_fault_a, i_predriver_fault_b})
		2'b01: nxt_err[`BFPM_ERR_OV] = 1'b1;
		2'b00: nxt_err[`BFPM_ERR_UV] = 1'b1;
		2'b10: nxt_err[`BFPM_ERR_SHORT] = 1'b1;
		default: ;
		endcase
		if (i_overcurrent)
			nxt_err[`BFPM_ERR_OC] = 1'b1;
		if (ms_tick && speed_ff > `BFPM_SPEED_MAX_RPM)
			nxt_err[`BFPM_ERR_SPEED] = 1'b1;
		if (ms_tick && run_en_ff && !commut_seen_ff && tmo_ms_ff >= `BFPM_TIMEOUT_MS - 1)
			nxt_err[`BFPM_ERR_TMO] = 1'b1;
		if (pat_bad_ff)
			nxt_err[`BFPM_ERR_PAT] = 1'b1;
		if (vbus_ff > ov_limit_ff)
			nxt_err[`BFPM_ERR_VBUS] = 1'b1;
	end

	always @* begin
		clr_req = i_wr && (i_addr == `BFPM_ADDR_STATUS);
	end

	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			err_ff <= {`BFPM_NERR{1'b0}};
		end else begin
			err_ff <= nxt_err;
		end
	end

	// Carrier-synchronous work: comparator pattern, speed sample, stop counter
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pat_ff <= 3'h0;
			pat_bad_ff <= 1'b0;
			speed_ff <= 16'h0;
			stop_cnt_ff <= 16'h0;
			vbus_ff <= 10'h0;
		end else if (carrier_tick) begin
			pat_ff <= i_comp_uvw;
			pat_bad_ff <= run_en_ff && (i_comp_uvw == 3'h0 || i_comp_uvw == 3'h7);
			speed_ff <= i_rotation_speed;
			stop_cnt_ff <= 16'h0;
			vbus_ff <= i_bus_voltage_adc;
		end else begin
			pat_bad_ff <= 1'b0;
			if (stop_cnt_ff != 16'hFFFF)
				stop_cnt_ff <= stop_cnt_ff + 16'h1;
		end
	end

	// Millisecond work: commutation timeout and start-time count
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tmo_ms_ff <= 5'h0;
			commut_seen_ff <= 1'b0;
			start_ms_ff <= 16'h0;
		end else begin
			if (ms_tick) begin
				commut_seen_ff <= i_commutation;
				if (commut_seen_ff || i_commutation || !run_en_ff)
					tmo_ms_ff <= 5'h0;
				else if (tmo_ms_ff != 5'h1F)
					tmo_ms_ff <= tmo_ms_ff + 5'h1;
				if (run_en_ff && start_ms_ff != 16'hFFFF)
					start_ms_ff <= start_ms_ff + 16'h1;
			end else if (i_commutation) begin
				commut_seen_ff <= 1'b1;
			end
			if (!run_en_ff)
				start_ms_ff <= 16'h0;
		end
	end

	// Control register
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			run_en_ff <= 1'b0;
			ov_limit_ff <= `BFPM_OV_LIMIT_RST;
		end else begin
			if (i_wr && i_addr == `BFPM_ADDR_CTRL)
				run_en_ff <= i_wdata[0];
			else if (stop_any)
				run_en_ff <= 1'b0;
			if (i_wr && i_addr == `BFPM_ADDR_OVLIM)
				ov_limit_ff <= i_wdata[9:0];
		end
	end

	// Output stage: active high gates, output enables cleared on any stop
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_u_upper_pwm <= 1'b0;
			o_u_lower_pwm <= 1'b0;
			o_v_upper_pwm <= 1'b0;
			o_v_lower_pwm <= 1'b0;
			o_w_upper_pwm <= 1'b0;
			o_w_lower_pwm <= 1'b0;
			o_pwm_oe <= 6'h00;
			o_fault_stop <= 1'b0;
			o_overcurrent_irq <= 1'b0;
			o_carrier_sync_irq <= 1'b0;
			o_millisecond_tick_irq <= 1'b0;
			o_modulation_vbus <= 10'h000;
		end else begin
			o_u_upper_pwm <= i_pwm_timer[0];
			o_u_lower_pwm <= i_pwm_timer[1];
			o_v_upper_pwm <= i_pwm_timer[2];
			o_v_lower_pwm <= i_pwm_timer[3];
			o_w_upper_pwm <= i_pwm_timer[4];
			o_w_lower_pwm <= i_pwm_timer[5];
			if (i_overcurrent || stop_any || !run_en_ff)
				o_pwm_oe <= 6'h00;
			else
				o_pwm_oe <= 6'h3F;
			o_fault_stop <= stop_any || i_overcurrent;
			o_overcurrent_irq <= i_overcurrent && !err_ff[`BFPM_ERR_OC];
			o_carrier_sync_irq <= carrier_tick;
			o_millisecond_tick_irq <= ms_tick;
			if (carrier_tick)
				o_modulation_vbus <= i_bus_voltage_adc;
		end
	end

	// Register read port
	always @* begin
		if (i_addr == `BFPM_ADDR_CTRL)
			rd_mux = {15'h0, run_en_ff};
		else if (i_addr == `BFPM_ADDR_STATUS)
			rd_mux = {8'h0, err_ff};
		else if (i_addr == `BFPM_ADDR_SPEED)
			rd_mux = speed_ff;
		else if (i_addr == `BFPM_ADDR_OVLIM)
			rd_mux = {6'h0, ov_limit_ff};
		else if (i_addr == `BFPM_ADDR_PWM)
			rd_mux = {5'h0, pat_ff, 2'h0, o_pwm_oe};
		else if (i_addr == `BFPM_ADDR_VBUS)
			rd_mux = {6'h0, vbus_ff};
		else if (i_addr == `BFPM_ADDR_TICKS)
			rd_mux = start_ms_ff;
		else
			rd_mux = 16'h0000;
	end

	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_rdata <= 16'h0000;
		else if (i_rd)
			o_rdata <= rd_mux;
		else
			o_rdata <= 16'h0000;
	end
endmodule

/* File: bfpm_chk_asserts.sv */
// Checker for the motor fault protection monitor
module bfpm_chk (
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_predriver_fault_a,
	input wire i_predriver_fault_b,
	input wire i_overcurrent,
	input wire [5:0] i_pwm_timer,
	input wire o_u_upper_pwm,
	input wire o_w_lower_pwm,
	input wire [5:0] o_pwm_oe,
	input wire o_overcurrent_irq,
	input wire o_carrier_sync_irq,
	input wire o_fault_stop
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	sequence s_oc;
		i_overcurrent;
	endsequence
	sequence s_predrv;
		!(i_predriver_fault_a && i_predriver_fault_b);
	endsequence
	a_oc_oe_off: assert property (s_oc |=> o_pwm_oe == 6'h00) else $error("oe on");
	a_oc_stop_set: assert property (s_oc |=> o_fault_stop) else $error("no stop");
	a_oc_irq_pulse: assert property (o_overcurrent_irq |=> !o_overcurrent_irq)
		else $error("irq long");
	a_oc_irq_cause: assert property (o_overcurrent_irq |-> $past(i_overcurrent))
		else $error("irq cause");
	a_predrv_stop: assert property (s_predrv |-> ##[1:2] o_fault_stop)
		else $error("no stop");
	a_stop_oe_off: assert property ($past(o_fault_stop) |-> o_pwm_oe == 6'h00)
		else $error("oe on");
	a_gate_copy: assert property (!$past(i_sys_rst) |-> o_u_upper_pwm == $past(i_pwm_timer[0])
		&& o_w_lower_pwm == $past(i_pwm_timer[5])) else $error("gate");
	a_carrier_pulse: assert property (o_carrier_sync_irq |=> (!o_carrier_sync_irq) [*8])
		else $error("tick");
endmodule
bind bfpm_monitor bfpm_chk u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
	.i_predriver_fault_a(i_predriver_fault_a), .i_predriver_fault_b(i_predriver_fault_b),
	.i_overcurrent(i_overcurrent), .i_pwm_timer(i_pwm_timer), .o_u_upper_pwm(o_u_upper_pwm),
	.o_w_lower_pwm(o_w_lower_pwm), .o_pwm_oe(o_pwm_oe), .o_overcurrent_irq(o_overcurrent_irq),
	.o_carrier_sync_irq(o_carrier_sync_irq), .o_fault_stop(o_fault_stop));

/* File: bfpm_bridge_model.sv */
// Pre-driver fault lines and phase comparators
module bfpm_bridge_model (
	input wire [1:0] i_code,
	input wire [2:0] i_pattern,
	output wire o_fault_a,
	output wire o_fault_b,
	output wire [2:0] o_comp_uvw
);
	timeunit 1ns;
	timeprecision 1ps;
	assign o_fault_a = i_code[1];
	assign o_fault_b = i_code[0];
	assign o_comp_uvw = i_pattern;
endmodule

/* File: tb_top.sv */
// Testbench for the motor fault protection monitor
`include "bfpm_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	reg i_clk_sys = 1'b0;
	reg i_sys_rst = 1'b1;
	reg i_overcurrent = 1'b0;
	reg i_commutation = 1'b0;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	reg [1:0] code = 2'b11;
	reg [2:0] pattern = 3'b101;
	reg [5:0] i_pwm_timer = 6'h00;
	reg [3:0] i_addr = 4'h0;
	reg [15:0] i_wdata = 16'h0000;
	reg [15:0] speed_in = 16'h1000;
	reg [9:0] vbus_in = 10'h100;
	wire fa, fb, oc_irq, cs_irq, ms_irq, stop;
	wire [2:0] comp;
	wire [5:0] pwm, oe;
	wire [9:0] vbus;
	wire [15:0] o_rdata;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	bfpm_bridge_model u_bridge (.i_code(code), .i_pattern(pattern), .o_fault_a(fa),
		.o_fault_b(fb), .o_comp_uvw(comp));
	bfpm_monitor dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_predriver_fault_a(fa),
		.i_predriver_fault_b(fb), .i_overcurrent(i_overcurrent), .i_comp_uvw(comp),
		.i_commutation(i_commutation), .i_rotation_speed(speed_in), .i_bus_voltage_adc(vbus_in),
		.i_pwm_timer(i_pwm_timer), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_u_upper_pwm(pwm[0]), .o_u_lower_pwm(pwm[1]), .o_v_upper_pwm(pwm[2]),
		.o_v_lower_pwm(pwm[3]), .o_w_upper_pwm(pwm[4]), .o_w_lower_pwm(pwm[5]), .o_pwm_oe(oe),
		.o_overcurrent_irq(oc_irq), .o_carrier_sync_irq(cs_irq), .o_millisecond_tick_irq(ms_irq),
		.o_fault_stop(stop), .o_modulation_vbus(vbus));
	initial forever #5 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		i_commutation <= (cyc % 4000 == 0);
		if (cyc == 40000) begin
			failures = failures + 1;
			complete_run();
		end
	end
	task complete_run;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string n, input [15:0] e, input [15:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task rdchk(input string n, input [3:0] a, input [15:0] e);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		@(negedge i_clk_sys);
		chk(n, e, o_rdata);
	endtask
	task rearm;
		wr(`BFPM_ADDR_STATUS, 16'h0000);
		wr(`BFPM_ADDR_CTRL, 16'h0001);
		repeat (3) @(posedge i_clk_sys);
	endtask
	task t_reset;
		@(negedge i_clk_sys);
		chk("oe", 16'h0000, {10'h000, oe});
		rdchk("status", `BFPM_ADDR_STATUS, 16'h0000);
		rdchk("ovlim", `BFPM_ADDR_OVLIM, 16'h03B0);
		rdchk("unmapped", 4'hF, 16'h0000);
	endtask
	task t_run;
		rearm;
		i_pwm_timer <= 6'h15;
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk("oe", 16'h003F, {10'h000, oe});
		chk("gates", 16'h0015, {10'h000, pwm});
		rdchk("pwm reg", `BFPM_ADDR_PWM, 16'h003F);
	endtask
	task t_predrv;
		for (int i = 0; i < 3; i++) begin
			@(posedge i_clk_sys);
			code <= {i == 2, i == 0};
			repeat (3) @(posedge i_clk_sys);
			code <= 2'b11;
			@(negedge i_clk_sys);
			chk("stop", 16'h0001, {15'h0000, stop});
			rdchk("cause", `BFPM_ADDR_STATUS, 16'h0001 << i);
			chk("oe", 16'h0000, {10'h000, oe});
			rearm;
		end
	endtask
	task t_oc;
		i_overcurrent <= 1'b1;
		@(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk("oc irq", 16'h0001, {15'h0000, oc_irq});
		chk("oe", 16'h0000, {10'h000, oe});
		@(posedge i_clk_sys);
		i_overcurrent <= 1'b0;
		@(negedge i_clk_sys);
		chk("oc irq", 16'h0000, {15'h0000, oc_irq});
		rdchk("cause", `BFPM_ADDR_STATUS, 16'h0001 << `BFPM_ERR_OC);
		rearm;
	endtask
	task t_pattern;
		int n;
		n = 0;
		pattern <= 3'b000;
		while (cs_irq !== 1'b1 && n < 12000) begin
			@(negedge i_clk_sys);
			n++;
		end
		chk("tick", 16'h0001, {15'h0000, cs_irq});
		chk("ms tick", 16'h0000, {15'h0000, ms_irq});
		repeat (3) @(posedge i_clk_sys);
		pattern <= 3'b101;
		rdchk("cause", `BFPM_ADDR_STATUS, 16'h0001 << `BFPM_ERR_PAT);
		rdchk("speed", `BFPM_ADDR_SPEED, 16'h1000);
		chk("vbus", 16'h0100, {6'h00, vbus});
		rearm;
	endtask
	task t_vbus;
		wr(`BFPM_ADDR_OVLIM, 16'h00FF);
		rdchk("ovlim", `BFPM_ADDR_OVLIM, 16'h00FF);
		@(negedge i_clk_sys);
		chk("stop", 16'h0001, {15'h0000, stop});
		rdchk("cause", `BFPM_ADDR_STATUS, 16'h0001 << `BFPM_ERR_VBUS);
		rdchk("run", `BFPM_ADDR_CTRL, 16'h0000);
		wr(`BFPM_ADDR_OVLIM, {6'h00, `BFPM_OV_LIMIT_RST});
		rearm;
		rdchk("status", `BFPM_ADDR_STATUS, 16'h0000);
	endtask
	initial begin
		repeat (4) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		t_reset;
		t_run;
		t_predrv;
		t_oc;
		t_pattern;
		t_vbus;
		complete_run;
	end
endmodule
